// ### logic/fdt_tone_mode_control.sv
// Top of the FSK/DTMF tone and mode control block.
`timescale 1ns/100ps
`default_nettype none
`include "fdt_params.svh"
module fdt_tone_mode_control #(
  parameter int unsigned ON_CYC = `FDT_ON_CYC,
  parameter int unsigned OFF_CYC = `FDT_OFF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] tx_tones,
  input wire logic [7:0] modem_mode_control,
  input wire logic [7:0] setup,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_bit,
  input wire logic [`FDT_LVL_W-1:0] rx_level,
  input wire logic [`FDT_LVL_W-1:0] threshold,
  input wire logic [15:0] rx_freq_hz,
  output var fdt_pkg::fdt_det_e det_mode,
  output logic detect_flag,
  output logic demod_enable,
  output logic mod_active,
  output logic [10:0] tone_a_hz,
  output logic [10:0] tone_b_hz,
  output logic level_high,
  output logic dtmf_selected
);
  fdt_pkg::fdt_det_e next_det_mode;
  fdt_pkg::fdt_tx_s tx, next_tx;
  logic next_demod;

  // Keypad pair lookup, shared by pair and single-tone paths.
  function automatic fdt_pkg::fdt_pair_s dtmf_pair(input logic [3:0] code);
    fdt_pkg::fdt_pair_s p;
    p = '{low_hz: 11'h3AD, high_hz: 11'h661};
    unique case (code)
      4'h0: p = '{low_hz: 11'h3AD, high_hz: 11'h661};
      4'h1: p = '{low_hz: 11'h2B9, high_hz: 11'h4B9};
      4'h2: p = '{low_hz: 11'h2B9, high_hz: 11'h538};
      4'h3: p = '{low_hz: 11'h2B9, high_hz: 11'h5C5};
      4'h4: p = '{low_hz: 11'h302, high_hz: 11'h4B9};
      4'h5: p = '{low_hz: 11'h302, high_hz: 11'h538};
      4'h6: p = '{low_hz: 11'h302, high_hz: 11'h5C5};
      4'h7: p = '{low_hz: 11'h354, high_hz: 11'h4B9};
      4'h8: p = '{low_hz: 11'h354, high_hz: 11'h538};
      4'h9: p = '{low_hz: 11'h354, high_hz: 11'h5C5};
      4'hA: p = '{low_hz: 11'h3AD, high_hz: 11'h538};
      4'hB: p = '{low_hz: 11'h3AD, high_hz: 11'h4B9};
      4'hC: p = '{low_hz: 11'h3AD, high_hz: 11'h5C5};
      4'hD: p = '{low_hz: 11'h2B9, high_hz: 11'h661};
      4'hE: p = '{low_hz: 11'h302, high_hz: 11'h661};
      4'hF: p = '{low_hz: 11'h354, high_hz: 11'h661};
    endcase
    return p;
  endfunction

  // Single tone: the upper tone for digits 0..7, the lower tone from 8 up.
  function automatic logic [10:0] single_tone(input logic [3:0] code);
    fdt_pkg::fdt_pair_s p;
    p = dtmf_pair(code);
    return (code[3] && code != 4'h0) ? p.low_hz : p.high_hz;
  endfunction

  always_comb begin
    fdt_pkg::fdt_pair_s pair;
    logic fast;
    pair = dtmf_pair(tx_nibble);
    fast = modem_mode_control[`FDT_MODE_FAST];
    // Detector mode; the undocumented 1/x0 combinations fall back to call progress.
    unique case ({tx_tones[`FDT_TONE_DET_EN], modem_mode_control[`FDT_MODE_RX_B5],
                  modem_mode_control[`FDT_MODE_RX_B4]})
      3'b010: next_det_mode = fdt_pkg::FDT_DET_LOW;
      3'b011: next_det_mode = fdt_pkg::FDT_DET_FAST;
      3'b111: next_det_mode = fdt_pkg::FDT_DET_2100;
      default: next_det_mode = fdt_pkg::FDT_DET_CALL;
    endcase
    next_demod = modem_mode_control[`FDT_MODE_TX_EN] && modem_mode_control[`FDT_MODE_RX_B5];
    next_tx = '0;
    next_tx.high_level = modem_mode_control[`FDT_MODE_HI_LVL];
    next_tx.is_dtmf = tx_tones[`FDT_TONE_DTMF];
    if (setup[`FDT_SETUP_BELL]) begin
      next_tx.space_hz = fast ? 11'h898 : 11'h1E7;
      next_tx.mark_hz = fast ? 11'h4B0 : 11'h183;
    end else begin
      next_tx.space_hz = fast ? 11'h834 : 11'h1C2;
      next_tx.mark_hz = fast ? 11'h514 : 11'h186;
    end
    if (tx_tones[`FDT_TONE_DTMF]) begin
      next_tx.active = tx_tones[`FDT_TONE_OUT_EN];
      if (tx_tones[`FDT_TONE_SINGLE]) begin
        next_tx.tone_a_hz = single_tone(tx_nibble);
        next_tx.tone_b_hz = 11'h000;
      end else begin
        next_tx.tone_a_hz = pair.low_hz;
        next_tx.tone_b_hz = pair.high_hz;
      end
    end else begin
      // Mode bit 1 low idles the modulator at mid-supply whatever bit 0 is.
      next_tx.active = modem_mode_control[`FDT_MODE_TX_EN];
      next_tx.tone_a_hz = tx_bit ? next_tx.mark_hz : next_tx.space_hz;
      next_tx.tone_b_hz = 11'h000;
    end
    if (!next_tx.active) begin
      next_tx.tone_a_hz = 11'h000;
      next_tx.tone_b_hz = 11'h000;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      det_mode <= fdt_pkg::FDT_DET_CALL;
      demod_enable <= 1'b0;
      tx <= '0;
    end else begin
      det_mode <= next_det_mode;
      demod_enable <= next_demod;
      tx <= next_tx;
    end
  end

  always_comb begin
    mod_active = tx.active;
    tone_a_hz = tx.tone_a_hz;
    tone_b_hz = tx.tone_b_hz;
    level_high = tx.high_level;
    dtmf_selected = tx.is_dtmf;
  end

  fdt_detector #(
    .ON_CYC(ON_CYC),
    .OFF_CYC(OFF_CYC)
  ) u_detector (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .det_mode(det_mode),
    .rx_level(rx_level),
    .threshold(threshold),
    .rx_freq_hz(rx_freq_hz),
    .detect(detect_flag)
  );
endmodule
`default_nettype wire

// ### common/fdt_params.svh
// Constants for the FSK/DTMF tone and mode control block.
// How it works
// - Detector mode from tone bit0, mode bits5:4.
// - 2100 Hz mode flags qualified 2100 Hz tone.
// - Tone bit0 clear compares level against threshold.
// - Flag after qualifying time, amplitude/time hysteresis.
// - FSK with mode bit1 clear: modulator idles mid-supply.
// - V.23 selects 450/390 or 2100/1300 Hz.
// - Bell 202 selects 487/387 or 2200/1200 Hz.
// - DTMF mode: tone bit6 gates modulator output.
// - DTMF nibbles 1-9 map to keypad pairs.
// - DTMF nibbles A-F and 0 map remaining pairs.
// - Single-tone mode maps nibble to one tone.
// - Mode bit2 raises transmit level 3 dB.
// - Demodulator enabled when mode bits 1,5 set.
`ifndef FDT_PARAMS_SVH
`define FDT_PARAMS_SVH
`define FDT_CLK_HZ 100000000
`define FDT_TONE_DET_EN 0
`define FDT_TONE_SINGLE 4
`define FDT_TONE_OUT_EN 6
`define FDT_TONE_DTMF 7
`define FDT_MODE_FAST 0
`define FDT_MODE_TX_EN 1
`define FDT_MODE_HI_LVL 2
`define FDT_MODE_RX_B4 4
`define FDT_MODE_RX_B5 5
`define FDT_SETUP_BELL 7
`define FDT_LVL_W 12
`define FDT_LVL_HYST 12'h040
`define FDT_ON_TIME_US 25000
`define FDT_OFF_TIME_US 15000
`define FDT_ON_CYC (`FDT_ON_TIME_US * (`FDT_CLK_HZ / 1000000))
`define FDT_OFF_CYC (`FDT_OFF_TIME_US * (`FDT_CLK_HZ / 1000000))
`define FDT_F2100_LO 16'h081F
`define FDT_F2100_HI 16'h0849
`endif

// ### common/fdt_pkg.sv
// Types for the FSK/DTMF tone and mode control block.
package fdt_pkg;
  typedef enum logic [1:0] {
    FDT_DET_CALL = 2'b00,
    FDT_DET_LOW = 2'b01,
    FDT_DET_FAST = 2'b11,
    FDT_DET_2100 = 2'b10
  } fdt_det_e;
  typedef enum logic [1:0] {
    FDT_EN_OFF = 2'b00,
    FDT_EN_QUAL = 2'b01,
    FDT_EN_ON = 2'b11,
    FDT_EN_DROP = 2'b10
  } fdt_en_e;
  typedef struct packed {
    logic [10:0] low_hz;
    logic [10:0] high_hz;
  } fdt_pair_s;
  typedef struct packed {
    logic active;
    logic [10:0] space_hz;
    logic [10:0] mark_hz;
    logic [10:0] tone_a_hz;
    logic [10:0] tone_b_hz;
    logic high_level;
    logic is_dtmf;
  } fdt_tx_s;
endpackage

// ### logic/fdt_detector.sv
// Energy and 2100 Hz detector qualifier with amplitude and time hysteresis.
`timescale 1ns/100ps
`default_nettype none
`include "fdt_params.svh"
module fdt_detector #(
  parameter int unsigned ON_CYC = `FDT_ON_CYC,
  parameter int unsigned OFF_CYC = `FDT_OFF_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire fdt_pkg::fdt_det_e det_mode,
  input wire logic [`FDT_LVL_W-1:0] rx_level,
  input wire logic [`FDT_LVL_W-1:0] threshold,
  input wire logic [15:0] rx_freq_hz,
  output logic detect
);
  fdt_pkg::fdt_en_e state, next_state;
  logic [31:0] count, next_count;
  logic above, below, in_band;
  logic next_detect;
  logic [`FDT_LVL_W:0] thr_lo;

  always_comb begin
    thr_lo = {1'b0, threshold} - {1'b0, `FDT_LVL_HYST};
    in_band = (rx_freq_hz >= `FDT_F2100_LO) && (rx_freq_hz <= `FDT_F2100_HI);
    // Level comparison against threshold; 2100 mode also requires frequency.
    above = (rx_level > threshold) && (det_mode != fdt_pkg::FDT_DET_2100 || in_band);
    // Lower release threshold gives amplitude hysteresis.
    below = thr_lo[`FDT_LVL_W] || ({1'b0, rx_level} < thr_lo)
            || (det_mode == fdt_pkg::FDT_DET_2100 && !in_band);
    next_state = state;
    next_count = 32'h0;
    unique case (state)
      fdt_pkg::FDT_EN_OFF: begin
        if (above) next_state = fdt_pkg::FDT_EN_QUAL;
      end
      fdt_pkg::FDT_EN_QUAL: begin
        // Signal must persist for the on time before the flag rises.
        if (!above) begin
          next_state = fdt_pkg::FDT_EN_OFF;
        end else if (count >= ON_CYC - 1) begin
          next_state = fdt_pkg::FDT_EN_ON;
        end else begin
          next_count = count + 32'h1;
        end
      end
      fdt_pkg::FDT_EN_ON: begin
        if (below) next_state = fdt_pkg::FDT_EN_DROP;
      end
      fdt_pkg::FDT_EN_DROP: begin
        // Short dropouts are bridged so the flag does not chatter.
        if (!below) begin
          next_state = fdt_pkg::FDT_EN_ON;
        end else if (count >= OFF_CYC - 1) begin
          next_state = fdt_pkg::FDT_EN_OFF;
        end else begin
          next_count = count + 32'h1;
        end
      end
    endcase
    next_detect = (next_state == fdt_pkg::FDT_EN_ON) || (next_state == fdt_pkg::FDT_EN_DROP);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= fdt_pkg::FDT_EN_OFF;
      count <= 32'h0;
      detect <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      detect <= next_detect;
    end
  end
endmodule
`default_nettype wire

// ### tb/fdt_properties.sv
// Checker on the tone and mode control ports.
`timescale 1ns/100ps
`default_nettype none
module fdt_tone_checker #(
  parameter int unsigned ON_CYC = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] tx_tones,
  input wire logic [7:0] modem_mode_control,
  input wire logic [7:0] setup,
  input wire logic tx_bit,
  input wire logic [11:0] rx_level,
  input wire logic [11:0] threshold,
  input wire fdt_pkg::fdt_det_e det_mode,
  input wire logic detect_flag,
  input wire logic demod_enable,
  input wire logic mod_active,
  input wire logic [10:0] tone_a_hz,
  input wire logic [10:0] tone_b_hz
);
  // Saturates at 255, enough for the short qualifying counts used in simulation.
  logic [7:0] run_cnt;
  logic [7:0] next_run_cnt;
  always_comb next_run_cnt = (rx_level <= threshold) ? 8'h00 : run_cnt + {7'h00, ~&run_cnt};
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) run_cnt <= 8'h00;
    else run_cnt <= next_run_cnt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_fsk_on;
    !tx_tones[7] && modem_mode_control[1];
  endsequence
  AST_DET_2100: assert property (tx_tones[0] && modem_mode_control[5:4] == 2'b11 |=>
    det_mode == fdt_pkg::FDT_DET_2100) else $error("bad det_mode");
  AST_DEMOD: assert property (1'b1 |=> demod_enable ==
    ($past(modem_mode_control[1]) && $past(modem_mode_control[5]))) else $error("bad demod");
  AST_FSK_IDLE: assert property (!tx_tones[7] && !modem_mode_control[1] |=>
    !mod_active && tone_a_hz == 11'h000) else $error("modulator not idle");
  AST_DTMF_GATE: assert property (tx_tones[7] |=>
    mod_active == $past(tx_tones[6])) else $error("bad output gate");
  AST_SINGLE: assert property (tx_tones[7] && tx_tones[6] && tx_tones[4] |=>
    mod_active && tone_b_hz == 11'h000) else $error("bad single tone");
  AST_V23_FAST: assert property (s_fsk_on ##0 (modem_mode_control[0] && !setup[7] && tx_bit)
    |=> tone_a_hz == 11'h514) else $error("bad fast mark");
  AST_BELL_SLOW: assert property (s_fsk_on ##0 (!modem_mode_control[0] && setup[7] && !tx_bit)
    |=> tone_a_hz == 11'h1E7) else $error("bad slow space");
  AST_QUALIFY: assert property ($rose(detect_flag) |-> run_cnt >= ON_CYC)
    else $error("detect too early");
endmodule
bind fdt_tone_mode_control fdt_tone_checker #(.ON_CYC(ON_CYC)) chk_u (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .tx_tones(tx_tones),
  .modem_mode_control(modem_mode_control),
  .setup(setup),
  .tx_bit(tx_bit),
  .rx_level(rx_level),
  .threshold(threshold),
  .det_mode(det_mode),
  .detect_flag(detect_flag),
  .demod_enable(demod_enable),
  .mod_active(mod_active),
  .tone_a_hz(tone_a_hz),
  .tone_b_hz(tone_b_hz)
);
`default_nettype wire

// ### tb/fdt_line_model.sv
// Telephone line model that feeds receive level and frequency.
`timescale 1ns/100ps
`default_nettype none
module fdt_line_model (
  input wire logic sys_clk,
  input wire logic tone_on,
  input wire logic [11:0] tone_level,
  input wire logic [15:0] tone_freq,
  output logic [11:0] rx_level,
  output logic [15:0] rx_freq_hz
);
  logic [3:0] hiss = 4'h0;
  // A silent line still wanders, so idle values change every cycle.
  always @(posedge sys_clk) begin
    hiss <= hiss + 4'h7;
    rx_level <= tone_on ? tone_level : {8'h00, hiss};
    rx_freq_hz <= tone_on ? tone_freq : {hiss, 12'h0A5};
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the tone and mode control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  localparam int unsigned ON = 8;
  localparam int unsigned OFF = 5;
  localparam logic [31:0] ROW = 32'h93FA9503;
  localparam logic [31:0] COL = 32'hFE192493;
  localparam logic [43:0] LOWS = {11'h3AD, 11'h354, 11'h302, 11'h2B9};
  localparam logic [43:0] HIGHS = {11'h661, 11'h5C5, 11'h538, 11'h4B9};
  localparam logic [87:0] FSK = {11'h4B0, 11'h898, 11'h183, 11'h1E7, 11'h514, 11'h834,
    11'h186, 11'h1C2};
  int err_total = 0;
  int check_count = 0;
  int w;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_bit = 1'b0;
  logic tone_on = 1'b0;
  logic [7:0] tx_tones = 8'h00;
  logic [7:0] modem_mode_control = 8'h00;
  logic [7:0] setup = 8'h00;
  logic [3:0] tx_nibble = 4'h0;
  logic [11:0] threshold = 12'h200;
  logic [11:0] tone_level = 12'h300;
  logic [15:0] tone_freq = 16'h03E8;
  logic [11:0] rx_level;
  logic [15:0] rx_freq_hz;
  fdt_pkg::fdt_det_e det_mode;
  logic detect_flag, demod_enable, mod_active, level_high, dtmf_selected;
  logic [10:0] tone_a_hz, tone_b_hz;
  fdt_tone_mode_control #(.ON_CYC(ON), .OFF_CYC(OFF)) dut_u (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tx_tones(tx_tones),
    .modem_mode_control(modem_mode_control),
    .setup(setup),
    .tx_nibble(tx_nibble),
    .tx_bit(tx_bit),
    .rx_level(rx_level),
    .threshold(threshold),
    .rx_freq_hz(rx_freq_hz),
    .det_mode(det_mode),
    .detect_flag(detect_flag),
    .demod_enable(demod_enable),
    .mod_active(mod_active),
    .tone_a_hz(tone_a_hz),
    .tone_b_hz(tone_b_hz),
    .level_high(level_high),
    .dtmf_selected(dtmf_selected)
  );
  fdt_line_model line_u (
    .sys_clk(sys_clk),
    .tone_on(tone_on),
    .tone_level(tone_level),
    .tone_freq(tone_freq),
    .rx_level(rx_level),
    .rx_freq_hz(rx_freq_hz)
  );
  initial forever #5 sys_clk = ~sys_clk;
  // Pair tones come from a row and column code per nibble, as on a keypad.
  function automatic logic [22:0] exp_tx(logic [7:0] t, logic [7:0] m, logic [7:0] s,
    logic [3:0] k, logic b);
    logic [10:0] lo;
    logic [10:0] hi;
    lo = LOWS[ROW[2*k +: 2]*11 +: 11];
    hi = HIGHS[COL[2*k +: 2]*11 +: 11];
    if (t[7]) return !t[6] ? 23'h0 : t[4] ? {1'b1, k[3] ? lo : hi, 11'h000} : {1'b1, lo, hi};
    return !m[1] ? 23'h0 : {1'b1, FSK[{s[7], m[0], b}*11 +: 11], 11'h000};
  endfunction
  task automatic tick(int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic step(logic [7:0] t, logic [7:0] m, logic [7:0] s, logic [3:0] k, logic b);
    tx_tones = t;
    modem_mode_control = m;
    setup = s;
    tx_nibble = k;
    tx_bit = b;
    tick(1);
    `CHK({mod_active, tone_a_hz, tone_b_hz}, exp_tx(t, m, s, k, b))
    `CHK(det_mode, {m[5] & m[4], m[5] & ~t[0]})
    `CHK({demod_enable, level_high, dtmf_selected}, {m[1] & m[5], m[2], t[7]})
  endtask
  task automatic wait_flag(logic v);
    w = 0;
    while (detect_flag !== v && w < 60) begin
      tick(1);
      w++;
    end
    if (w == 60) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'hFD103F3A));
    repeat (10) @(posedge sys_clk);
    `CHK({mod_active, det_mode, detect_flag}, 4'h0)
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 32; i++) step({3'b110, i[4], 4'h0}, 8'h04, 8'h00, i[3:0], 1'b0);
    for (int i = 0; i < 32; i++) step({7'h00, i[0]}, {2'b00, i[2:1], 1'b0, i[4], 1'b1, i[3]},
      {i[4], 7'h00}, 4'h0, i[1]);
    repeat (400) step(8'($urandom), 8'($urandom), 8'($urandom), 4'($urandom), 1'($urandom));
    // A strong tone off frequency must not count as the answer tone.
    step(8'h01, 8'h30, 8'h00, 4'h0, 1'b0);
    tone_on = 1'b1;
    tick(30);
    `CHK(detect_flag, 1'b0)
    tone_freq = 16'h0834;
    wait_flag(1'b1);
    `CHK(w, ON + 2)
    tone_level = 12'h1E0;
    tick(30);
    `CHK(detect_flag, 1'b1)
    tone_on = 1'b0;
    wait_flag(1'b0);
    `CHK(w, OFF + 2)
    step(8'h00, 8'h00, 8'h00, 4'h0, 1'b0);
    tone_level = 12'h300;
    tone_freq = 16'h03E8;
    tone_on = 1'b1;
    wait_flag(1'b1);
    `CHK(detect_flag, 1'b1)
    `CHK(w, ON + 2)
    // A reset in mid-run must drop the flag at once and requalify from scratch.
    reset_n = 1'b0;
    tick(1);
    `CHK({mod_active, det_mode, detect_flag, demod_enable}, 5'h00)
    reset_n = 1'b1;
    wait_flag(1'b1);
    `CHK(w, ON + 1)
    print_verdict();
  end
endmodule
`default_nettype wire
